// *** hdl/bit_fifo.v ***
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module bit_fifo #(
	parameter WIDTH = 1,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire ref_clk, // system clock
	input wire rst_n, // synchronous reset, active low
	input wire in_valid, // write request
	output wire in_ready, // room for a word
	input wire [WIDTH-1:0] in_data, // word written
	output wire out_valid, // word available
	input wire out_ready, // reader takes the word
	output wire [WIDTH-1:0] out_data // oldest word
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wptr_r;
	reg [AW:0] rptr_r;
	wire full;
	wire empty;
	assign empty = (wptr_r == rptr_r);
	assign full = (wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
	assign in_ready = ~full;
	assign out_valid = ~empty;
	assign out_data = mem[rptr_r[AW-1:0]];
	always @(posedge ref_clk) begin
		if (in_valid && !full)
			mem[wptr_r[AW-1:0]] <= in_data;
	end
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			wptr_r <= {(AW+1){1'b0}};
			rptr_r <= {(AW+1){1'b0}};
		end else begin
			if (in_valid && !full)
				wptr_r <= wptr_r + 1'b1;
			if (out_ready && !empty)
				rptr_r <= rptr_r + 1'b1;
		end
	end
endmodule // bit_fifo
`default_nettype wire

// *** hdl/boundary_scan_data_path.v ***
// boundary scan tap, data registers and pin cells, oversampling the test clock
`timescale 1ns/1ps
`default_nettype none
`include "scan_path_consts.vh"
module boundary_scan_data_path (
	input wire ref_clk, // 200 MHz sampling clock
	input wire rst_n, // synchronous reset, active low
	input wire tck, // test clock pin
	input wire tms, // test mode select pin
	input wire tdi, // test data in pin
	input wire trst_n, // test reset pin, active low
	output reg tdo_r, // test data out
	output reg tdo_oe_r, // test data out enable
	input wire [23:0] lane_receive_positive, // receive lanes, positive
	input wire [23:0] lane_receive_negative, // receive lanes, negative
	input wire [7:0] mgmt_addr_pin, // management bus address straps
	input wire [10:0] strap_pin, // system strap and mode pins
	input wire [23:0] core_tx_data, // core transmit value per pair
	output reg [23:0] lane_transmit_positive, // transmit lanes, positive
	output reg [23:0] lane_transmit_negative, // transmit lanes, negative
	input wire [14:0] core_bidir_out, // core data to two-way pads
	input wire [14:0] core_bidir_oe, // core enable for two-way pads
	input wire [14:0] bidir_pad_in, // two-way pad level
	output reg [14:0] bidir_pad_out, // two-way pad drive value
	output reg [14:0] bidir_pad_oe, // two-way pad output enable
	output reg [14:0] core_bidir_in // synchronised pad level to core
);
	localparam [15:0] S_RESET = 16'h0001, S_IDLE = 16'h0002, S_SEL_DR = 16'h0004;
	localparam [15:0] S_CAP_DR = 16'h0008, S_SH_DR = 16'h0010, S_EX1_DR = 16'h0020;
	localparam [15:0] S_PA_DR = 16'h0040, S_EX2_DR = 16'h0080, S_UP_DR = 16'h0100;
	localparam [15:0] S_SEL_IR = 16'h0200, S_CAP_IR = 16'h0400, S_SH_IR = 16'h0800;
	localparam [15:0] S_EX1_IR = 16'h1000, S_PA_IR = 16'h2000, S_EX2_IR = 16'h4000;
	localparam [15:0] S_UP_IR = 16'h8000;
	localparam NPIN = 3 + 24 + 24 + 8 + 11 + 15;

	// pin side inputs cross into ref_clk through two flops; only stage two is read
	wire [NPIN-1:0] raw_in;
	reg [NPIN-1:0] s1_r;
	reg [NPIN-1:0] s2_r;
	assign raw_in = {tck, tms, tdi, lane_receive_positive, lane_receive_negative,
		mgmt_addr_pin, strap_pin, bidir_pad_in};
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			s1_r <= {NPIN{1'b0}};
			s2_r <= {NPIN{1'b0}};
		end else begin
			s1_r <= raw_in;
			s2_r <= s1_r;
		end
	end
	reg trst_s1_r;
	reg trst_s2_r;
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			trst_s1_r <= 1'b0;
			trst_s2_r <= 1'b0;
		end else begin
			trst_s1_r <= trst_n;
			trst_s2_r <= trst_s1_r;
		end
	end
	wire tck_s = s2_r[NPIN-1];
	wire tms_s = s2_r[NPIN-2];
	wire tdi_s = s2_r[NPIN-3];
	wire [14:0] pad_s = s2_r[14:0];
	wire [`N_IN_CELLS-1:0] in_cells = s2_r[NPIN-4:15];
	reg tck_d_r;
	always @(posedge ref_clk) begin
		if (!rst_n)
			tck_d_r <= 1'b0;
		else
			tck_d_r <= tck_s;
	end
	wire tck_rise = tck_s & ~tck_d_r;
	wire tck_fall = ~tck_s & tck_d_r;

	// tap controller
	reg [15:0] st_r;
	reg [15:0] st_nxt;
	always @* begin
		case (st_r)
		S_RESET: st_nxt = tms_s ? S_RESET : S_IDLE;
		S_IDLE: st_nxt = tms_s ? S_SEL_DR : S_IDLE;
		S_SEL_DR: st_nxt = tms_s ? S_SEL_IR : S_CAP_DR;
		S_CAP_DR: st_nxt = tms_s ? S_EX1_DR : S_SH_DR;
		S_SH_DR: st_nxt = tms_s ? S_EX1_DR : S_SH_DR;
		S_EX1_DR: st_nxt = tms_s ? S_UP_DR : S_PA_DR;
		S_PA_DR: st_nxt = tms_s ? S_EX2_DR : S_PA_DR;
		S_EX2_DR: st_nxt = tms_s ? S_UP_DR : S_SH_DR;
		S_UP_DR: st_nxt = tms_s ? S_SEL_DR : S_IDLE;
		S_SEL_IR: st_nxt = tms_s ? S_RESET : S_CAP_IR;
		S_CAP_IR: st_nxt = tms_s ? S_EX1_IR : S_SH_IR;
		S_SH_IR: st_nxt = tms_s ? S_EX1_IR : S_SH_IR;
		S_EX1_IR: st_nxt = tms_s ? S_UP_IR : S_PA_IR;
		S_PA_IR: st_nxt = tms_s ? S_EX2_IR : S_PA_IR;
		S_EX2_IR: st_nxt = tms_s ? S_UP_IR : S_SH_IR;
		S_UP_IR: st_nxt = tms_s ? S_SEL_DR : S_IDLE;
		default: st_nxt = S_RESET;
		endcase
	end
	always @(posedge ref_clk) begin
		if (!rst_n)
			st_r <= S_RESET;
		else if (!trst_s2_r)
			st_r <= S_RESET;
		else if (tck_rise)
			st_r <= st_nxt;
	end

	// instruction register: shift on rise, take effect on the falling edge of update
	reg [`IR_WIDTH-1:0] ir_sh_r;
	reg [`IR_WIDTH-1:0] ir_r;
	wire sel_bscan = (ir_r == `IR_EXTEST) || (ir_r == `IR_SAMPLE);
	wire sel_id = (ir_r == `IR_IDCODE);
	wire sel_bypass = !sel_bscan && !sel_id;
	wire extest = (ir_r == `IR_EXTEST);
	wire drive_latched = extest || (ir_r == `IR_CLAMP);
	wire highz = (ir_r == `IR_HIGHZ);

	// data registers
	reg bypass_r;
	reg [`IDCODE_WIDTH-1:0] id_r;
	reg [`CHAIN_LEN-1:0] chain_r;
	reg [`N_UPD_CELLS-1:0] upd_r;
	wire [14:0] upd_oe;
	wire [14:0] upd_dat;
	wire [14:0] eff_oe;
	wire [`N_UPD_CELLS-1:0] cap_upd;
	genvar g;
	generate
		for (g = 0; g < `N_BIDIR; g = g + 1) begin : bidir_cells
			assign upd_oe[g] = upd_r[`N_LANES + 2*g];
			assign upd_dat[g] = upd_r[`N_LANES + 2*g + 1];
			assign eff_oe[g] = drive_latched ? upd_oe[g] : core_bidir_oe[g];
			assign cap_upd[`N_LANES + 2*g] = eff_oe[g];
			// pad value when tri-stated or under external test, else core data
			assign cap_upd[`N_LANES + 2*g + 1] = (!extest && eff_oe[g]) ?
				core_bidir_out[g] : pad_s[g];
		end
	endgenerate
	assign cap_upd[`N_LANES-1:0] = core_tx_data;
	// input cells only observe, so they have no update stage
	wire [`CHAIN_LEN-1:0] chain_cap = {cap_upd, in_cells};

	wire sh_dr = (st_r == S_SH_DR);
	wire sh_ir = (st_r == S_SH_IR);
	wire dr_lsb = sel_bscan ? chain_r[0] : (sel_id ? id_r[0] : bypass_r);
	wire out_bit = sh_ir ? ir_sh_r[0] : dr_lsb;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [0:0] fifo_out_data;

	always @(posedge ref_clk) begin
		if (!rst_n || !trst_s2_r) begin
			ir_sh_r <= {`IR_WIDTH{1'b0}};
			ir_r <= `IR_RESET_VALUE;
			bypass_r <= 1'b0;
			id_r <= {`IDCODE_WIDTH{1'b0}};
			chain_r <= {`CHAIN_LEN{1'b0}};
			upd_r <= {`N_UPD_CELLS{1'b0}};
		end else if (tck_rise && fifo_in_ready) begin
			case (st_r)
			S_CAP_IR: ir_sh_r <= `IR_CAPTURE_VALUE;
			S_SH_IR: ir_sh_r <= {tdi_s, ir_sh_r[`IR_WIDTH-1:1]};
			S_CAP_DR: begin
				if (sel_bypass)
					bypass_r <= `BYPASS_CAPTURE;
				if (sel_id)
					id_r <= `IDCODE_VALUE;
				if (sel_bscan)
					chain_r <= chain_cap;
			end
			S_SH_DR: begin
				if (sel_bypass)
					bypass_r <= tdi_s;
				if (sel_id)
					id_r <= {tdi_s, id_r[`IDCODE_WIDTH-1:1]};
				if (sel_bscan)
					chain_r <= {tdi_s, chain_r[`CHAIN_LEN-1:1]};
			end
			default: ;
			endcase
		end else if (tck_fall) begin
			if (st_r == S_RESET)
				ir_r <= `IR_RESET_VALUE;
			else if (st_r == S_UP_IR)
				ir_r <= ir_sh_r;
			if (st_r == S_UP_DR && sel_bscan)
				upd_r <= chain_r[`CHAIN_LEN-1:`TX_BASE];
		end
	end

	// tdo bits queue in the fifo at the falling edge and leave it one clock later
	bit_fifo #(
		.WIDTH(`TDO_FIFO_WIDTH),
		.DEPTH(`TDO_FIFO_DEPTH),
		.AW(`TDO_FIFO_AW)
	) tdo_fifo (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.in_valid(tck_fall && (sh_dr || sh_ir)),
		.in_ready(fifo_in_ready),
		.in_data(out_bit),
		.out_valid(fifo_out_valid),
		.out_ready(1'b1),
		.out_data(fifo_out_data)
	);
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			tdo_r <= 1'b0;
			tdo_oe_r <= 1'b0;
		end else begin
			if (fifo_out_valid)
				tdo_r <= fifo_out_data[0];
			// test reset can strike with tck stopped, so it cannot wait for a fall
			if (!trst_s2_r)
				tdo_oe_r <= 1'b0;
			else if (tck_fall)
				tdo_oe_r <= sh_dr || sh_ir;
		end
	end

	// pin drivers: latched values under external test or clamp, pad enables off under highz, else straight from core
	wire [14:0] pad_out_nxt = drive_latched ? upd_dat : core_bidir_out;
	wire [14:0] pad_oe_nxt = highz ? 15'h0000 : eff_oe;
	wire [23:0] tx_nxt = drive_latched ? upd_r[`N_LANES-1:0] : core_tx_data;
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			lane_transmit_positive <= 24'h00_0000;
			lane_transmit_negative <= 24'hFF_FFFF;
			bidir_pad_out <= 15'h0000;
			bidir_pad_oe <= 15'h0000;
			core_bidir_in <= 15'h0000;
		end else begin
			lane_transmit_positive <= tx_nxt;
			lane_transmit_negative <= ~tx_nxt; // one data cell per pair
			bidir_pad_out <= pad_out_nxt;
			bidir_pad_oe <= pad_oe_nxt;
			core_bidir_in <= pad_s;
		end
	end
endmodule // boundary_scan_data_path
`default_nettype wire

// *** pkg/scan_path_consts.vh ***
// constants for the boundary scan data path
`ifndef SCAN_PATH_CONSTS_VH
`define SCAN_PATH_CONSTS_VH
`define IR_WIDTH 6
`define IR_EXTEST 6'h00
`define IR_SAMPLE 6'h01
`define IR_IDCODE 6'h02
`define IR_HIGHZ 6'h03
`define IR_CAPTURE_VALUE 6'h2D
`define IR_CLAMP 6'h3E
`define IR_BYPASS 6'h3F
`define IR_RESET_VALUE `IR_IDCODE
`define IDCODE_WIDTH 32
`define IDCODE_VALUE 32'h1234_5679 // arbitrary identity value, names no maker or part
`define BYPASS_CAPTURE 1'b0
`define N_LANES 24
`define N_ADDR 8
`define N_STRAP 11
`define N_BIDIR 15
`define N_IN_CELLS 67
`define TX_BASE 67
`define BIDIR_BASE 91
`define N_UPD_CELLS 54
`define CHAIN_LEN 121
`define TDO_FIFO_WIDTH 1
`define TDO_FIFO_DEPTH 32
`define TDO_FIFO_AW 5
`endif

// *** test/scan_controller_model.sv ***
// model of the board test controller driving the test port
`timescale 1ns/1ps
`default_nettype none
module scan_controller_model (
	input wire logic ref_clk, // bench clock
	input wire logic tdo_r, // serial data from the block
	input wire logic tdo_oe_r, // serial data enable from the block
	output logic tck, // test clock, still between frames
	output logic tms, // mode select
	output logic tdi, // serial data to the block
	output logic trst_n // test reset, active low
);
	logic oe_at_rise; // tdo enable seen just before the last rise
	logic oe_ok; // enable stayed high over every shifted bit
	initial begin
		oe_at_rise = 1'b0;
		oe_ok = 1'b0;
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		trst_n = 1'b0;
	end
	// one 125 ns test clock: tms and tdi set while low, tdo taken just before the rise
	task automatic step(input logic m, input logic d, output logic q);
		tms <= m;
		tdi <= d;
		repeat (13) @(posedge ref_clk);
		q = tdo_r;
		oe_at_rise = tdo_oe_r;
		tck <= 1'b1;
		repeat (12) @(posedge ref_clk);
		tck <= 1'b0;
	endtask
	// from run-test-idle through one register scan and back, lsb first
	task automatic scan(input logic ir, input int n, input logic [127:0] din,
		output logic [127:0] dout);
		logic q;
		dout = '0;
		oe_ok = 1'b1;
		step(1'b1, ~tdi, q);
		if (ir) step(1'b1, ~tdi, q);
		step(1'b0, ~tdi, q);
		step(1'b0, ~tdi, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
			oe_ok = oe_ok & oe_at_rise;
		end
		step(1'b1, ~tdi, q);
		step(1'b0, ~tdi, q);
	endtask
	// test reset pin, changed only at a bench clock edge
	task automatic set_trst(input logic v);
		trst_n <= v;
	endtask
endmodule // scan_controller_model
`default_nettype wire

// *** test/scan_path_sva.sv ***
// port checker for the boundary scan data path
`timescale 1ns/1ps
`default_nettype none
module scan_path_sva (
	input wire logic ref_clk, // sampling clock
	input wire logic rst_n, // reset, active low
	input wire logic tck, // test clock pin
	input wire logic trst_n, // test reset, active low
	input wire logic tdo_r, // test data out
	input wire logic tdo_oe_r, // test data out enable
	input wire logic [23:0] core_tx_data, // core transmit value
	input wire logic [23:0] lane_transmit_positive, // transmit lanes
	input wire logic [23:0] lane_transmit_negative, // transmit lanes, negative
	input wire logic [14:0] core_bidir_out, // core pad data
	input wire logic [14:0] core_bidir_oe, // core pad enable
	input wire logic [14:0] bidir_pad_out, // pad drive value
	input wire logic [14:0] bidir_pad_oe // pad enable
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	AST_TX_PAIR: assert property (lane_transmit_negative == ~lane_transmit_positive)
		else $error("transmit pair not complementary");
	AST_TDO_FALL: assert property ($changed(tdo_r) |-> !tck)
		else $error("tdo moved while tck high");
	AST_OE_FALL: assert property ($changed(tdo_oe_r) |-> !tck || !$past(trst_n, 3))
		else $error("tdo enable moved while tck high");
	AST_TRST_OFF: assert property ((!trst_n) [*6] |-> !tdo_oe_r)
		else $error("tdo driven during test reset");
	AST_TRST_TX: assert property ((!trst_n) [*6] |=> lane_transmit_positive == $past(core_tx_data))
		else $error("transmit lanes not from core in test reset");
	AST_TRST_PAD: assert property ((!trst_n) [*6] |=>
		{bidir_pad_oe, bidir_pad_out} == $past({core_bidir_oe, core_bidir_out}))
		else $error("two-way pads not from core in test reset");
	// a latched value only lands after a tck fall, so a non-core value never changes with tck high
	AST_TX_LATCH: assert property ($changed(lane_transmit_positive) &&
		lane_transmit_positive != $past(core_tx_data) |-> !tck)
		else $error("transmit latch changed while tck high");
	AST_OE_LATCH: assert property ($changed(bidir_pad_oe) &&
		bidir_pad_oe != $past(core_bidir_oe) |-> !tck)
		else $error("pad enable latch changed while tck high");
	cover property (tdo_oe_r);
	cover property ($changed(lane_transmit_positive) && !tck);
	cover property ((!trst_n) [*6]);
endmodule // scan_path_sva
bind boundary_scan_data_path scan_path_sva u_scan_path_sva (.ref_clk, .rst_n, .tck, .trst_n,
	.tdo_r, .tdo_oe_r, .core_tx_data, .lane_transmit_positive, .lane_transmit_negative,
	.core_bidir_out, .core_bidir_oe, .bidir_pad_out, .bidir_pad_oe);
`default_nettype wire

// *** test/testbench.sv ***
// testbench for the boundary scan data path
`timescale 1ns/1ps
`default_nettype none
`include "scan_path_consts.vh"
module testbench;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [23:0] lane_receive_positive = 24'h35_c00f, lane_receive_negative = 24'hca_3ff0;
	logic [7:0] mgmt_addr_pin = 8'h96;
	logic [10:0] strap_pin = 11'h2a5;
	logic [23:0] core_tx_data = 24'h0f_1e2d;
	logic [14:0] core_bidir_out = 15'h0f0f, core_bidir_oe = 15'h00ff, bidir_pad_in = 15'h3c3c;
	logic [127:0] pre = {8{16'hc35a}};
	int n_mismatch = 0, check_count = 0;
	wire logic tck, tms, tdi, trst_n, tdo_r, tdo_oe_r;
	wire logic [23:0] lane_transmit_positive, lane_transmit_negative;
	wire logic [14:0] bidir_pad_out, bidir_pad_oe, core_bidir_in;
	always #2.5 ref_clk = ~ref_clk;
	boundary_scan_data_path u_boundary_scan_data_path (.ref_clk, .rst_n, .tck, .tms, .tdi,
		.trst_n, .tdo_r, .tdo_oe_r, .lane_receive_positive, .lane_receive_negative,
		.mgmt_addr_pin, .strap_pin, .core_tx_data, .lane_transmit_positive,
		.lane_transmit_negative, .core_bidir_out, .core_bidir_oe, .bidir_pad_in,
		.bidir_pad_out, .bidir_pad_oe, .core_bidir_in);
	scan_controller_model u_ctrl (.ref_clk, .tdo_r, .tdo_oe_r, .tck, .tms, .tdi, .trst_n);
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic load_ir(input logic [5:0] code);
		logic [127:0] d;
		u_ctrl.scan(1'b1, 6, {122'h0, code}, d);
		chk(d[5:0], `IR_CAPTURE_VALUE);
		chk({tdo_oe_r, u_ctrl.oe_ok}, 2'b01);
	endtask
	task automatic sample_pins;
		logic [127:0] d;
		logic [29:0] got, exp;
		load_ir(`IR_SAMPLE);
		u_ctrl.scan(1'b0, `CHAIN_LEN, pre, d);
		for (int i = 0; i < 15; i++) begin
			got[2*i+:2] = d[91+2*i+:2];
			exp[2*i+:2] = {core_bidir_oe[i] ? core_bidir_out[i] : bidir_pad_in[i], core_bidir_oe[i]};
		end
		chk(d[66:0], {lane_receive_positive, lane_receive_negative, mgmt_addr_pin, strap_pin});
		chk(got, exp);
		chk(d[90:67], core_tx_data);
		chk(core_bidir_in, bidir_pad_in);
	endtask
	task automatic drive_latches;
		logic [127:0] d;
		logic [29:0] got;
		load_ir(`IR_EXTEST);
		core_tx_data <= ~core_tx_data;
		repeat (4) @(posedge ref_clk);
		for (int i = 0; i < 15; i++) got[2*i+:2] = {bidir_pad_out[i], bidir_pad_oe[i]};
		chk(lane_transmit_positive, pre[90:67]);
		chk(got, pre[120:91]);
		u_ctrl.scan(1'b0, `CHAIN_LEN, pre, d);
		for (int i = 0; i < 15; i++) got[i] = d[92+2*i];
		chk(got[14:0], bidir_pad_in);
	endtask
	task automatic tms_reset;
		logic q;
		repeat (5) u_ctrl.step(1'b1, 1'b0, q);
		u_ctrl.step(1'b0, 1'b1, q);
		repeat (4) @(posedge ref_clk);
		chk(lane_transmit_positive, core_tx_data);
		chk({bidir_pad_oe, bidir_pad_out}, {core_bidir_oe, core_bidir_out});
	endtask
	task automatic trst_mid;
		logic [127:0] d;
		logic q;
		load_ir(`IR_EXTEST);
		chk(lane_transmit_positive, pre[90:67]);
		u_ctrl.set_trst(1'b0);
		repeat (8) @(posedge ref_clk);
		chk(lane_transmit_positive, core_tx_data);
		chk({bidir_pad_oe, bidir_pad_out}, {core_bidir_oe, core_bidir_out});
		u_ctrl.set_trst(1'b1);
		repeat (8) @(posedge ref_clk);
		u_ctrl.step(1'b0, 1'b0, q);
		u_ctrl.scan(1'b0, `IDCODE_WIDTH, 128'h0, d);
		chk(d[31:0], `IDCODE_VALUE);
	endtask
	// test reset cleared the update latches, so clamp must drive zeros
	task automatic hold_modes;
		logic [127:0] d;
		load_ir(`IR_HIGHZ);
		chk(bidir_pad_oe, 15'h0000);
		load_ir(`IR_CLAMP);
		chk({lane_transmit_positive, bidir_pad_oe, bidir_pad_out}, 54'h0);
		u_ctrl.scan(1'b0, 4, 128'h5, d);
		chk(d[3:0], 4'ha);
	endtask
	task automatic bypass_path;
		logic [127:0] d;
		load_ir(`IR_BYPASS);
		u_ctrl.scan(1'b0, 8, 128'h00a5, d);
		chk(d[7:0], 8'h4a);
	endtask
	task automatic test_done;
		if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		logic q;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge ref_clk);
		u_ctrl.set_trst(1'b1);
		repeat (8) @(posedge ref_clk);
		u_ctrl.step(1'b0, 1'b0, q);
		sample_pins;
		drive_latches;
		tms_reset;
		trst_mid;
		hold_modes;
		bypass_path;
		test_done;
	end
	initial begin
		#200000;
		n_mismatch++;
		test_done;
	end
endmodule // testbench
`default_nettype wire
